//--- rtl/uhde_executor.sv
// transfer descriptor executor: general and isochronous descriptors
// assumes a fetch engine hands over one decoded descriptor at a time and a
// packet engine runs each USB transaction and returns one result per packet
// Operation
// - build packets at cursor, advance on success
// - write each packet outcome as completion code
// - first toggle from endpoint unless upper bit set
// - retire copies toggle lower bit to endpoint
// - whole buffer moved: retire to completed list
// - short packet: complete if allowed, else error+halt
// - isochronous endpoints run iso descriptors
// - frame_span plus one packets, one per frame
// - packet index is frame minus first frame
// - start address from offset, page select bit 12
// - end address next offset minus one, last ends buffer; code takes the end page from the current offset's page select
// - overwrite offset entry with status word per frame
// - 11-bit byte count, zero on OUT
// - untouched code marks entry still unprocessed
// - write overall code when iso descriptor retires
// - completion interrupt delayed by irq_delay frames
// - codes: 0000 ok, 1001 short, 111x untouched
// - retry transmission errors, retire after three
//
// Added by the designer: the address-and-strobe port and the register addresses.
module uhde_executor
  import uhde_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_CYCLES
) (
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // register port
  input  wire logic [3:0]   regAddr,
  input  wire logic [31:0]  regWrData,
  input  wire logic         regWrite,
  input  wire logic         regRead,
  output logic [31:0]       regRdData,
  // descriptor hand-over
  input  wire logic         tdValid,
  input  wire uhde_td_type  tdIn,
  output logic              tdReady,
  // packet engine
  output uhde_pkt_type      pktReq,
  input  wire uhde_res_type pktRes,
  // memory write-back and completion interrupt
  output uhde_wb_type       wbOut,
  output logic              doneIrq
);

  // ----------------------------------------------------------------
  // frame timer
  // ----------------------------------------------------------------
  logic        run_q, run_d;
  logic        frameTick;
  logic [15:0] frameNumber;

  uhde_frame_timer #(.FRAME_LEN(FRAME_LEN)) u_frame (
    .clk_sys     (clk_sys),
    .nrst        (nrst),
    .run         (run_q),
    .frameTick   (frameTick),
    .frameNumber (frameNumber)
  );

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_GEN_ISSUE = 3'b001,
    ST_GEN_WAIT  = 3'b010,
    ST_ISO_SCAN  = 3'b011,
    ST_ISO_WAIT  = 3'b100,
    ST_RETIRE    = 3'b101
  } uhde_state_type;

  uhde_state_type state_q, state_d;
  uhde_td_type    td_q, td_d;
  logic           toggle_q, toggle_d;
  logic [1:0]     errCnt_q, errCnt_d;
  logic [3:0]     code_q, code_d;
  logic           halt_q, halt_d;
  logic [ISO_MAX_PKTS-1:0] doneMask_q, doneMask_d;
  logic [2:0]     curIdx_q, curIdx_d;
  logic           tdReady_q, tdReady_d;
  uhde_pkt_type   pkt_q, pkt_d;
  uhde_wb_type    wb_q, wb_d;
  logic           irqPend_q, irqPend_d;
  logic [2:0]     irqCnt_q, irqCnt_d;
  logic           irq_q, irq_d;

  // iso address and general packet helpers
  logic [15:0] isoDiff;
  logic [2:0]  isoIdx;
  logic [15:0] entryCur, entryNext;
  logic [19:0] isoUpper;
  logic [11:0] isoEndLow;
  logic [31:0] cursorNext;
  logic        isShort;
  logic        txError;

  always_comb begin
    isoDiff    = frameNumber - td_q.firstFrameIndex;
    isoIdx     = isoDiff[2:0];
    entryCur   = td_q.offsetEntry[isoIdx];
    entryNext  = td_q.offsetEntry[3'(isoIdx + 3'h1)];
    isoUpper   = entryCur[OFFSET_SEL] ? td_q.bufferLastAddress[31:ADDR_LOW_W]
                                      : td_q.bufferPageBase;
    isoEndLow  = entryNext[ADDR_LOW_W-1:0] - 12'h001;
    cursorNext = td_q.bufferCursor + {21'h0, pktRes.byteCount};
    isShort    = pktRes.byteCount < td_q.maxPacketLength;
    txError    = (pktRes.code == CC_CRC) || (pktRes.code == CC_BITSTUFF) ||
                 (pktRes.code == CC_NORESP);
  end

  // ----------------------------------------------------------------
  // descriptor engine
  // ----------------------------------------------------------------
  always_comb begin
    state_d    = state_q;
    td_d       = td_q;
    toggle_d   = toggle_q;
    errCnt_d   = errCnt_q;
    code_d     = code_q;
    halt_d     = halt_q;
    doneMask_d = doneMask_q;
    curIdx_d   = curIdx_q;
    pkt_d      = '0;
    wb_d       = '0;
    irqPend_d  = irqPend_q;
    irqCnt_d   = irqCnt_q;
    irq_d      = 1'b0;
    tdReady_d  = 1'b0;

    unique case (state_q)
      ST_IDLE: begin
        tdReady_d = run_q;
        if (tdValid && tdReady_q) begin
          tdReady_d  = 1'b0;
          td_d       = tdIn;
          errCnt_d   = 2'h0;
          code_d     = CC_NOERROR;
          halt_d     = 1'b0;
          doneMask_d = '0;
          // only the low bit is meaningful when the upper bit selects it
          toggle_d   = tdIn.toggleField[1] ? tdIn.toggleField[0]
                                           : tdIn.carriedToggle;
          state_d    = tdIn.isIso ? ST_ISO_SCAN : ST_GEN_ISSUE;
        end
      end

      ST_GEN_ISSUE: begin
        pkt_d.valid     = 1'b1;
        pkt_d.dirIn     = td_q.dirIn;
        pkt_d.dataPid   = toggle_q;
        pkt_d.startAddr = td_q.bufferCursor;
        pkt_d.endAddr   = td_q.bufferLastAddress;
        state_d         = ST_GEN_WAIT;
      end

      ST_GEN_WAIT: begin
        if (pktRes.valid) begin
          wb_d.valid = 1'b1;
          wb_d.kind  = WB_GEN;
          wb_d.code  = pktRes.code;
          wb_d.data  = td_q.bufferCursor;
          if (pktRes.code == CC_NOERROR) begin
            td_d.bufferCursor = cursorNext;
            wb_d.data         = cursorNext;
            toggle_d          = ~toggle_q;
            errCnt_d          = 2'h0;
            if (td_q.dirIn && isShort) begin
              if (!td_q.shortPacketOk) begin
                code_d    = CC_UNDERRUN;
                wb_d.code = CC_UNDERRUN;
                halt_d    = 1'b1;
              end
              state_d = ST_RETIRE;
            end else if (cursorNext > td_q.bufferLastAddress) begin
              state_d = ST_RETIRE;
            end else begin
              state_d = ST_GEN_ISSUE;
            end
          end else if (txError && errCnt_q != TX_ERR_LIMIT) begin
            errCnt_d = errCnt_q + 2'h1;
            state_d  = ST_GEN_ISSUE;
          end else begin
            code_d  = pktRes.code;
            halt_d  = 1'b1;
            state_d = ST_RETIRE;
          end
        end
      end

      ST_ISO_SCAN: begin
        if (!isoDiff[15]) begin
          if (isoDiff > {13'h0, td_q.frameSpan}) begin
            // last packet missed its frame: overall code reports it
            code_d  = doneMask_q[td_q.frameSpan] ? CC_NOERROR : CC_OVERRUN;
            state_d = ST_RETIRE;
          end else if (!doneMask_q[isoIdx] &&
                       entryCur[15:13] == UNTOUCHED_TOP) begin
            pkt_d.valid     = 1'b1;
            pkt_d.isIso     = 1'b1;
            pkt_d.dirIn     = td_q.dirIn;
            pkt_d.startAddr = {isoUpper, entryCur[ADDR_LOW_W-1:0]};
            pkt_d.endAddr   = (isoIdx == td_q.frameSpan)
                            ? td_q.bufferLastAddress
                            : {isoUpper, isoEndLow};
            curIdx_d        = isoIdx;
            state_d         = ST_ISO_WAIT;
          end
        end
      end

      ST_ISO_WAIT: begin
        if (pktRes.valid) begin
          doneMask_d[curIdx_q] = 1'b1;
          wb_d.valid = 1'b1;
          wb_d.kind  = WB_PSW;
          wb_d.index = curIdx_q;
          wb_d.code  = pktRes.code;
          wb_d.data  = {16'h0, pktRes.code, 1'b0,
                        td_q.dirIn ? pktRes.byteCount : 11'h000};
          td_d.offsetEntry[curIdx_q] = wb_d.data[15:0];
          state_d    = ST_ISO_SCAN;
        end
      end

      ST_RETIRE: begin
        wb_d.valid         = 1'b1;
        wb_d.kind          = WB_RETIRE;
        wb_d.code          = code_q;
        wb_d.haltEndpoint  = halt_q;
        wb_d.carriedToggle = toggle_q;
        wb_d.data          = td_q.nextDescriptor;
        if (td_q.irqDelay != IRQ_NEVER) begin
          irqPend_d = 1'b1;
          irqCnt_d  = td_q.irqDelay;
        end
        state_d = ST_IDLE;
      end

      default: state_d = ST_IDLE;
    endcase

    // frame-delayed completion interrupt
    if (irqPend_q && state_q != ST_RETIRE) begin
      if (irqCnt_q == 3'h0) begin
        irq_d     = 1'b1;
        irqPend_d = 1'b0;
      end else if (frameTick) begin
        irqCnt_d = irqCnt_q - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_q    <= ST_IDLE;
      td_q       <= '0;
      toggle_q   <= 1'b0;
      errCnt_q   <= 2'h0;
      code_q     <= CC_NOERROR;
      halt_q     <= 1'b0;
      doneMask_q <= '0;
      curIdx_q   <= 3'h0;
      tdReady_q  <= 1'b0;
      pkt_q      <= '0;
      wb_q       <= '0;
      irqPend_q  <= 1'b0;
      irqCnt_q   <= 3'h0;
      irq_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      td_q       <= td_d;
      toggle_q   <= toggle_d;
      errCnt_q   <= errCnt_d;
      code_q     <= code_d;
      halt_q     <= halt_d;
      doneMask_q <= doneMask_d;
      curIdx_q   <= curIdx_d;
      tdReady_q  <= tdReady_d;
      pkt_q      <= pkt_d;
      wb_q       <= wb_d;
      irqPend_q  <= irqPend_d;
      irqCnt_q   <= irqCnt_d;
      irq_q      <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic [31:0] rd_q, rd_d;

  always_comb begin
    run_d = run_q;
    rd_d  = 32'h0000_0000;
    if (regWrite && regAddr == REG_CTRL) begin
      // stopping takes effect at the next idle; a running general descriptor finishes, an iso one stalls with the stopped frame timer
      run_d = regWrData[CTRL_RUN_BIT];
    end
    if (regRead) begin
      unique case (regAddr)
        REG_CTRL:   rd_d = {31'h0, run_q};
        REG_STATUS: rd_d = {16'h0, 5'h0, state_q, code_q, errCnt_q, halt_q,
                            toggle_q};
        REG_FRAME:  rd_d = {16'h0, frameNumber};
        default:    rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      run_q <= CTRL_RUN_RESET;
      rd_q  <= 32'h0000_0000;
    end else begin
      run_q <= run_d;
      rd_q  <= rd_d;
    end
  end

  assign regRdData = rd_q;
  assign tdReady   = tdReady_q;
  assign pktReq    = pkt_q;
  assign wbOut     = wb_q;
  assign doneIrq   = irq_q;

endmodule

//--- rtl/uhde_pkg.sv
// shared constants, codes and carriers of the descriptor executor
// assumes one 250 MHz clock; descriptor fetch and USB packet engine live outside
package uhde_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int FRAME_TIME_NS = 1000000;
  localparam int FRAME_CYCLES  = FRAME_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_FRAME  = 4'h8;
  localparam int         CTRL_RUN_BIT   = 0;
  localparam logic       CTRL_RUN_RESET = 1'b0;

  // ----------------------------------------------------------------
  // completion codes and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] CC_NOERROR  = 4'h0;
  localparam logic [3:0] CC_CRC      = 4'h1;
  localparam logic [3:0] CC_BITSTUFF = 4'h2;
  localparam logic [3:0] CC_NORESP   = 4'h5;
  localparam logic [3:0] CC_OVERRUN  = 4'h8;
  localparam logic [3:0] CC_UNDERRUN = 4'h9;
  localparam logic [2:0] UNTOUCHED_TOP = 3'h7;
  localparam logic [1:0] TX_ERR_LIMIT  = 2'h2;
  localparam logic [2:0] IRQ_NEVER     = 3'h7;
  localparam int PSW_CC_LSB    = 12;
  localparam int PSW_SIZE_W    = 11;
  localparam int ADDR_LOW_W    = 12;
  localparam int OFFSET_SEL    = 12;
  localparam int ISO_MAX_PKTS  = 8;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WB_GEN    = 2'b00,
    WB_PSW    = 2'b01,
    WB_RETIRE = 2'b10
  } uhde_wb_kind_type;

  typedef struct packed {
    logic                             isIso;
    logic                             dirIn;
    logic [1:0]                       toggleField;
    logic                             carriedToggle;
    logic                             shortPacketOk;
    logic [2:0]                       irqDelay;
    logic [10:0]                      maxPacketLength;
    logic [31:0]                      bufferCursor;
    logic [31:0]                      bufferLastAddress;
    logic [31:0]                      nextDescriptor;
    logic [15:0]                      firstFrameIndex;
    logic [2:0]                       frameSpan;
    logic [19:0]                      bufferPageBase;
    logic [ISO_MAX_PKTS-1:0][15:0]    offsetEntry;
  } uhde_td_type;

  typedef struct packed {
    logic        valid;
    logic        isIso;
    logic        dirIn;
    logic        dataPid;
    logic [31:0] startAddr;
    logic [31:0] endAddr;
  } uhde_pkt_type;

  typedef struct packed {
    logic        valid;
    logic [3:0]  code;
    logic [10:0] byteCount;
  } uhde_res_type;

  typedef struct packed {
    logic             valid;
    uhde_wb_kind_type kind;
    logic [2:0]       index;
    logic [3:0]       code;
    logic             haltEndpoint;
    logic             carriedToggle;
    logic [31:0]      data;
  } uhde_wb_type;

endpackage

//--- rtl/uhde_frame_timer.sv
// frame timer: one-cycle frame tick from a divider and the frame number
// assumes clk_sys only; length of a frame is a parameter so benches can shorten it
module uhde_frame_timer
  import uhde_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  // control
  input  wire logic        run,
  // frame outputs
  output logic             frameTick,
  output logic [15:0]      frameNumber
);

  localparam int CW = $clog2(FRAME_LEN);

  // a one-cycle frame would leave the divider without a count
  if (FRAME_LEN < 2) begin
    $error("FRAME_LEN must be at least 2");
  end

  logic [CW-1:0] divCnt_q, divCnt_d;
  logic          tick_q, tick_d;
  logic [15:0]   frame_q, frame_d;

  always_comb begin
    divCnt_d = divCnt_q;
    tick_d   = 1'b0;
    frame_d  = frame_q;
    if (run) begin
      if (divCnt_q == CW'(FRAME_LEN - 1)) begin
        divCnt_d = '0;
        tick_d   = 1'b1;
        frame_d  = frame_q + 16'h0001;
      end else begin
        divCnt_d = divCnt_q + CW'(1);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      divCnt_q <= '0;
      tick_q   <= 1'b0;
      frame_q  <= 16'h0000;
    end else begin
      divCnt_q <= divCnt_d;
      tick_q   <= tick_d;
      frame_q  <= frame_d;
    end
  end

  assign frameTick   = tick_q;
  assign frameNumber = frame_q;

endmodule

//--- tb/uhde_executor_checker.sv
// concurrent checks on the executor's top-level ports
// assumes one clock domain; bound to every uhde_executor instance
module uhde_executor_checker
  import uhde_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_CYCLES
) (
  // clock and reset
  input wire logic         clk_sys,
  input wire logic         nrst,
  // register port
  input wire logic [3:0]   regAddr,
  input wire logic [31:0]  regWrData,
  input wire logic         regWrite,
  input wire logic         regRead,
  input wire logic [31:0]  regRdData,
  // descriptor, packet and write-back
  input wire logic         tdValid,
  input wire uhde_td_type  tdIn,
  input wire logic         tdReady,
  input wire uhde_pkt_type pktReq,
  input wire uhde_res_type pktRes,
  input wire uhde_wb_type  wbOut,
  input wire logic         doneIrq
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  logic       dirInQ;
  logic [2:0] irqDelayQ;
  logic       take;
  assign take = tdValid && tdReady;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dirInQ    <= 1'b0;
      irqDelayQ <= 3'h0;
    end else begin
      if (pktReq.valid) dirInQ <= pktReq.dirIn;
      if (take) irqDelayQ <= tdIn.irqDelay;
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_read_quiet: assert property (!$past(regRead) |-> regRdData == 32'h0)
    else $error("read data outside answer cycle");
  a_take_drop: assert property (take |=> !tdReady)
    else $error("ready stayed high after take");
  a_gen_start: assert property (take && !tdIn.isIso |->
    ##2 (pktReq.valid && pktReq.startAddr == $past(tdIn.bufferCursor, 2)))
    else $error("general packet not at cursor");
  a_first_pid: assert property (take && !tdIn.isIso |-> ##2
    pktReq.dataPid == $past(tdIn.toggleField[1] ? tdIn.toggleField[0] : tdIn.carriedToggle, 2))
    else $error("wrong first data pid");
  a_gen_cause: assert property (wbOut.valid && wbOut.kind == WB_GEN |->
    $past(pktRes.valid))
    else $error("general write-back without result");
  a_psw_pack: assert property (wbOut.valid && wbOut.kind == WB_PSW |->
    $past(pktRes.valid) && wbOut.data[15:12] == $past(pktRes.code) && !wbOut.data[11])
    else $error("status word packing");
  a_psw_count: assert property (wbOut.valid && wbOut.kind == WB_PSW |->
    wbOut.data[10:0] == (dirInQ ? $past(pktRes.byteCount) : 11'h0))
    else $error("status word byte count");
  a_ok_no_halt: assert property (wbOut.valid && wbOut.kind == WB_RETIRE
    && wbOut.code == CC_NOERROR |-> !wbOut.haltEndpoint)
    else $error("halt on clean retire");
  a_retire_ready: assert property (wbOut.valid && wbOut.kind == WB_RETIRE |->
    ##[1:2] tdReady)
    else $error("no ready after retire");
  a_irq_never: assert property (doneIrq |-> irqDelayQ != IRQ_NEVER)
    else $error("interrupt while suppressed");
  a_irq_now: assert property (wbOut.valid && wbOut.kind == WB_RETIRE
    && irqDelayQ == 3'h0 |-> ##[1:2] doneIrq)
    else $error("immediate interrupt missing");

  c_halt: cover property (wbOut.valid && wbOut.kind == WB_RETIRE && wbOut.haltEndpoint);
  c_psw: cover property (wbOut.valid && wbOut.kind == WB_PSW);
  c_irq: cover property (doneIrq);
endmodule

bind uhde_executor uhde_executor_checker #(.FRAME_LEN(FRAME_LEN)) uhde_executor_checker_inst (
  .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .tdValid(tdValid),
  .tdIn(tdIn), .tdReady(tdReady), .pktReq(pktReq), .pktRes(pktRes), .wbOut(wbOut),
  .doneIrq(doneIrq));

//--- tb/uhde_pkt_model.sv
// packet engine stand-in: answers each request one cycle later
// assumes the bench scripts the outcome code and byte count
module uhde_pkt_model
  import uhde_pkg::*;
(
  // clock and reset
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  // request and scripted outcome
  input  wire uhde_pkt_type pktReq,
  input  wire logic [3:0]   cfgCode,
  input  wire logic [10:0]  cfgCount,
  // result
  output uhde_res_type      pktRes
);
  timeunit 1ns;
  timeprecision 1ps;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pktRes <= '0;
    end else if (pktReq.valid) begin
      pktRes <= '{valid: 1'b1, code: cfgCode, byteCount: cfgCount};
    end else begin
      // idle fields keep moving so a stale value is never mistaken for data
      pktRes <= '{valid: 1'b0, code: ~pktRes.code, byteCount: ~pktRes.byteCount};
    end
  end
endmodule

//--- tb/uhde_executor_tb_top.sv
// directed bench for the descriptor executor
// assumes the packet model on the far side and a 20-cycle frame
module uhde_executor_tb_top
  import uhde_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clk_sys = 1'b0;
  logic         nrst;
  logic [3:0]   regAddr;
  logic [31:0]  regWrData;
  logic         regWrite;
  logic         regRead;
  logic [31:0]  regRdData;
  logic         tdValid;
  uhde_td_type  tdIn;
  logic         tdReady;
  uhde_pkt_type pktReq;
  uhde_res_type pktRes;
  uhde_wb_type  wbOut;
  logic         doneIrq;
  logic [3:0]   mCode;
  logic [10:0]  mCount;
  int           failures;
  int           n_tests;

  always #2 clk_sys = ~clk_sys;

  uhde_executor #(.FRAME_LEN(20)) uhde_executor_inst (
    .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .tdValid(tdValid),
    .tdIn(tdIn), .tdReady(tdReady), .pktReq(pktReq), .pktRes(pktRes), .wbOut(wbOut),
    .doneIrq(doneIrq));

  uhde_pkt_model uhde_pkt_model_inst (
    .clk_sys(clk_sys), .nrst(nrst), .pktReq(pktReq), .cfgCode(mCode),
    .cfgCount(mCount), .pktRes(pktRes));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (failures == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      failures++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask

  task automatic hang();
    chk(1'b0, "wait timed out");
    tally_and_finish();
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRead <= 1'b0;
    @(posedge clk_sys);
    d = regRdData;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWrite  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  task automatic give(input uhde_td_type t);
    int i;
    @(posedge clk_sys);
    tdIn    <= t;
    tdValid <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (tdReady !== 1'b1 && i < 100);
    tdValid <= 1'b0;
    if (i >= 100) hang();
  endtask

  task automatic wait_wb(input uhde_wb_kind_type k, output uhde_wb_type w);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge clk_sys);
      if (wbOut.valid === 1'b1 && wbOut.kind === k) break;
    end
    if (i == 300) hang();
    w = wbOut;
  endtask

  task automatic wait_pkt(output uhde_pkt_type p);
    int i;
    for (i = 0; i < 300; i++) begin
      @(posedge clk_sys);
      if (pktReq.valid === 1'b1) break;
    end
    if (i == 300) hang();
    p = pktReq;
  endtask

  task automatic gen(input uhde_td_type t, input logic [3:0] c, input logic [10:0] n,
                     input logic [3:0] ec, input logic eh, input logic et);
    uhde_wb_type w;
    mCode  <= c;
    mCount <= n;
    give(t);
    if (!eh) begin
      wait_wb(WB_GEN, w);
      chk(w.data === t.bufferCursor + n && w.code === CC_NOERROR, "cursor");
    end
    wait_wb(WB_RETIRE, w);
    chk(w.code === ec && w.haltEndpoint === eh &&
        w.data === t.nextDescriptor, "retire");
    if (!eh) chk(w.carriedToggle === et, "carried toggle");
  endtask

  task automatic iso(input logic dir);
    uhde_td_type  t;
    uhde_pkt_type p;
    uhde_wb_type  w;
    logic [31:0]  f;
    int           r;
    rd(REG_FRAME, f);
    t = '0;
    t.isIso = 1'b1;
    t.dirIn = dir;
    t.frameSpan = 3'h1;
    t.firstFrameIndex = f[15:0] + 16'h2;
    t.bufferPageBase = 20'h12345;
    t.bufferLastAddress = 32'habcde7ff;
    t.nextDescriptor = 32'h3000;
    t.offsetEntry[0] = 16'he100;
    t.offsetEntry[1] = 16'hf200;
    mCode  <= CC_NOERROR;
    mCount <= 11'h5;
    give(t);
    for (r = 0; r < 2; r++) begin
      wait_pkt(p);
      chk(p.isIso === 1'b1 &&
          p.startAddr === (r ? 32'habcde200 : 32'h12345100), "start");
      chk(p.endAddr === (r ? 32'habcde7ff : 32'h123451ff), "end");
      wait_wb(WB_PSW, w);
      chk(w.index === r[2:0] &&
          w.data[15:0] === {4'h0, 1'b0, dir ? 11'h5 : 11'h0}, "psw");
    end
    wait_wb(WB_RETIRE, w);
    chk(w.code === CC_NOERROR && w.haltEndpoint === 1'b0 &&
        w.data === 32'h3000, "iso retire");
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    uhde_td_type t;
    logic [31:0] d;
    nrst = 1'b0;
    regAddr = 4'h0;
    regWrData = 32'h0;
    regWrite = 1'b0;
    regRead = 1'b0;
    tdValid = 1'b0;
    tdIn = '0;
    mCode = 4'h0;
    mCount = 11'h0;
    failures = 0;
    n_tests = 0;
    repeat (2) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(REG_CTRL, d);
    chk(d === 32'h0, "ctrl reset value");
    rd(4'hc, d);
    chk(d === 32'h0, "unmapped read");
    wr(REG_FRAME, 32'hffff);
    rd(REG_FRAME, d);
    chk(d === 32'h0, "frame stopped and read only");
    wr(REG_CTRL, 32'h1);
    rd(REG_CTRL, d);
    chk(d === 32'h1, "ctrl run");
    t = '0;
    t.dirIn = 1'b1;
    t.maxPacketLength = 11'h40;
    t.bufferCursor = 32'h1000;
    t.bufferLastAddress = 32'h103f;
    t.nextDescriptor = 32'h2000;
    t.carriedToggle = 1'b1;
    gen(t, CC_NOERROR, 11'h40, CC_NOERROR, 1'b0, 1'b0);
    t.toggleField = 2'b10;
    gen(t, CC_NOERROR, 11'h40, CC_NOERROR, 1'b0, 1'b1);
    t.toggleField = 2'b00;
    gen(t, CC_NOERROR, 11'ha, CC_UNDERRUN, 1'b1, 1'b0);
    t.shortPacketOk = 1'b1;
    t.carriedToggle = 1'b0;
    gen(t, CC_NOERROR, 11'ha, CC_NOERROR, 1'b0, 1'b1);
    t.irqDelay = IRQ_NEVER;
    gen(t, CC_CRC, 11'h0, CC_CRC, 1'b1, 1'b0);
    rd(REG_STATUS, d);
    chk(d === 32'h0000_001a, "status after error retire");
    iso(1'b1);
    iso(1'b0);
    tally_and_finish();
  end
endmodule
